// *** hw/bank_cfg_if.sv ***
// Per-bank settings passed from the top to the bank decoder.
// Assumes eight chip-select banks.
`timescale 1ns/100ps
`default_nettype none
`include "memctl_consts.svh"
interface bank_cfg_if;
  logic [`BANK_COUNT-1:0] bankEn;
  logic [`BANK_COUNT-1:0] bankBig;
  logic [`BANK_COUNT-1:0] hit;
  modport top (output bankEn, output bankBig, input hit);
  modport dec (input bankEn, input bankBig, output hit);
endinterface
`default_nettype wire

// *** hw/bank_decoder.sv ***
// Compares an external address against each enabled chip-select bank.
// Assumes bank base b sits at b MB above the internal region, or at (b+1)*16 MB in 16 MB mode.
`timescale 1ns/100ps
`default_nettype none
`include "memctl_consts.svh"
module bank_decoder (
  input  wire logic [31:0] addr,
  bank_cfg_if.dec          cfg
);
  genvar b;
  generate
    for (b = 0; b < `BANK_COUNT; b++)
    begin : g_bank
      logic [31:0] base;
      logic        inSmall;
      logic        inBig;
      assign base    = cfg.bankBig[b] ? (32'(b + 1) << `MB16_SHIFT)
                                      : (32'(b + 4) << `MB1_SHIFT);
      assign inSmall = (addr >> `MB1_SHIFT) == (base >> `MB1_SHIFT);
      assign inBig   = (addr >> `MB16_SHIFT) == (base >> `MB16_SHIFT);
      // Large banks are only four, so banks four and up never hit in 16 MB mode.
      assign cfg.hit[b] = cfg.bankEn[b] & (cfg.bankBig[b] ? (inBig & (b < 4)) : inSmall);
    end
  endgenerate
endmodule // bank_decoder
`default_nettype wire

// *** hw/memctl_consts.svh ***
// Constants for the memory map decoder and boot remap logic.
// Assumes inclusion by bare name from the design files only.
`ifndef MEMCTL_CONSTS_SVH
`define MEMCTL_CONSTS_SVH
`define INT_TOP_ADDR      32'h0040_0000
`define PER_BASE_ADDR     32'hffc0_0000
`define VEC_TOP_ADDR      32'h0000_0020
`define STRAP_HOLD_CYC    4'd10
`define STRAP_CNT_W       4
`define BANK_COUNT        8
`define WAIT_W            3
`define FLOAT_W           3
`define MB1_SHIFT         20
`define MB16_SHIFT        24
`define BANK_SEL_W        3
`endif

// *** hw/memctl_pkg.sv ***
// Types shared by the memory map decoder files.
// Assumes no other package.
package memctl_pkg;
  typedef enum logic [1:0] {
    REG_INT = 2'b00,
    REG_EXT = 2'b01,
    REG_PER = 2'b11
  } region_e;
  typedef enum logic [1:0] {
    ACC_BYTE = 2'b00,
    ACC_HALF = 2'b01,
    ACC_WORD = 2'b10
  } size_e;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_FLOAT = 2'b11
  } ext_state_e;
endpackage

// *** hw/memory_map_boot_remap_decoder.sv ***
// Memory map decoder: regions, boot remap, aborts and external bank timing.
// Assumes a core that holds a request until ready and one clock domain.
//
// Summary of operation
// - Split 32-bit address into internal, external and peripheral regions.
// - All regions use little-endian byte lanes only.
// - SRAM completes byte, half and word accesses in one cycle.
// - After remap, SRAM appears at address zero.
// - Exception vectors occupy addresses zero to 0x20.
// - Strap stable ten cycles before reset release is latched.
// - Strap one means 8-bit boot, zero means 16-bit boot on CS0.
// - Strap pin becomes ordinary general I/O after reset.
// - Writing one to the remap bit swaps boot memory and SRAM.
// - Remap cleared only by internal or pin reset.
// - Undefined external addresses raise abort.
// - No abort for internal reads or peripheral accesses; before remap, misaligned boot reads abort.
// - External unit handles 0x0040_0000 up to 0xffc0_0000.
// - Banks range from eight 1 MB to four 16 MB.
// - Per-bank wait states and data float cycles.
// - Per-bank 8-bit or 16-bit data width.
// - 16-bit banks use byte select or byte write mode.
// - Early read protocol selectable per device.
// - Accesses aligned to their own size are supported.
// - Flash is addressed as 16-bit words on A1 to A20.
// - Watchdog reset keeps the latched boot mode.
`timescale 1ns/100ps
`default_nettype none
`include "memctl_consts.svh"
module memory_map_boot_remap_decoder #(
  parameter int BANKS = `BANK_COUNT
) (
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  pinReset,
  input  wire logic                  boot_width_strap,
  input  wire logic                  gpioOut,
  input  wire logic                  gpioOe_n,
  output logic                       gpioIn,
  output logic                       strapOut,
  output logic                       strapOe_n,
  input  wire logic                  remap_command_bit,
  input  wire logic [BANKS-1:0]      bankEn,
  input  wire logic [BANKS-1:0]      bankBig,
  input  wire logic [BANKS-1:0]      bankWide,
  input  wire logic [BANKS-1:0]      bankByteWrite,
  input  wire logic [BANKS-1:0]      bankEarlyRead,
  input  wire logic [BANKS*`WAIT_W-1:0]  bankWait,
  input  wire logic [BANKS*`FLOAT_W-1:0] bankFloat,
  input  wire logic                  req,
  input  wire logic                  wr,
  input  wire logic [1:0]            size,
  input  wire logic [31:0]           addr,
  input  wire logic [31:0]           wdata,
  output logic                       ready,
  output logic                       abort,
  output logic                       remapDone,
  output logic                       bootByteWide,
  output logic [1:0]                 region,
  output logic                       sramSel,
  output logic                       sramWe,
  output logic [3:0]                 sramBe,
  output logic [31:0]                sramAddr,
  output logic [31:0]                sramWdata,
  output logic                       perSel,
  output logic [31:0]                perAddr,
  output logic [BANKS-1:0]           chipSel_n,
  output logic [23:0]                extAddr,
  output logic [15:0]                extData,
  output logic                       extRead_n,
  output logic                       extWrite_n,
  output logic [1:0]                 extByteSel_n,
  output logic                       extBusy
);
  bank_cfg_if cfg ();
  memctl_pkg::region_e    reg_w;
  memctl_pkg::ext_state_e st_r;
  logic                   remap_r;
  logic [BANKS-1:0]       hit;
  logic [BANKS-1:0]       hitGated;
  logic                   bootWin;
  logic                   extDefined;
  logic                   extReq;
  logic [`BANK_SEL_W-1:0] selIdx;
  logic [`WAIT_W-1:0]     cnt_r;
  logic [3:0]             be;
  logic                   aligned;
  assign cfg.bankEn  = bankEn;
  assign cfg.bankBig = bankBig;
  assign hit         = cfg.hit;
  bank_decoder u_dec (
    .addr (addr),
    .cfg  (cfg)
  );
  strap_latch u_strap (
    .sys_clk      (sys_clk),
    .sys_rst      (sys_rst),
    .pinReset     (pinReset),
    .strapPin     (boot_width_strap),
    .bootByteWide (bootByteWide)
  );
  // The strap pin is shared with a general I/O line once reset is over.
  assign gpioIn    = boot_width_strap;
  assign strapOut  = gpioOut;
  assign strapOe_n = pinReset | gpioOe_n;
  // Region decode.
  always_comb
    if (addr < `INT_TOP_ADDR)
      reg_w = memctl_pkg::REG_INT;
    else if (addr >= `PER_BASE_ADDR)
      reg_w = memctl_pkg::REG_PER;
    else
      reg_w = memctl_pkg::REG_EXT;
  assign region = reg_w;
  // Remap is sticky; only a reset clears it.
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
      remap_r <= 1'b0;
    else if (remap_command_bit)
      remap_r <= 1'b1;
  assign remapDone = remap_r;
  // Before remap the whole internal region shows the boot memory.
  assign bootWin  = !remap_r && reg_w == memctl_pkg::REG_INT;
  // Chip selects other than zero are unreachable until remap.
  assign hitGated = remap_r ? hit : (hit & {{(BANKS-1){1'b0}}, 1'b1});
  assign extDefined = bootWin || (|hitGated);
  assign extReq     = req && (bootWin || reg_w == memctl_pkg::REG_EXT);
  always_comb
  begin
    selIdx = '0;
    for (int i = BANKS - 1; i >= 0; i--)
      if (hitGated[i])
        selIdx = `BANK_SEL_W'(i);
    if (bootWin)
      selIdx = '0;
  end
  // Little-endian lanes and natural alignment.
  always_comb
    case (size)
      memctl_pkg::ACC_BYTE: be = 4'h1 << addr[1:0];
      memctl_pkg::ACC_HALF: be = addr[1] ? 4'hc : 4'h3;
      default:              be = 4'hf;
    endcase
  assign aligned = size == memctl_pkg::ACC_BYTE ||
                   (size == memctl_pkg::ACC_HALF && !addr[0]) ||
                   (size == memctl_pkg::ACC_WORD && addr[1:0] == 2'h0);
  // SRAM is combinational single cycle; no abort in peripheral space or, after remap, in internal space.
  assign sramSel   = req && reg_w == memctl_pkg::REG_INT && remap_r;
  assign sramWe    = sramSel && wr;
  assign sramBe    = be;
  assign sramAddr  = addr;
  assign sramWdata = wdata;
  assign perSel    = req && reg_w == memctl_pkg::REG_PER;
  // Peripherals see a word address with the low bits masked.
  assign perAddr   = {addr[31:2], 2'h0};
  assign abort     = extReq && (!extDefined || !aligned)
                     && st_r == memctl_pkg::ST_IDLE;
  // External access sequencer.
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
      st_r <= memctl_pkg::ST_IDLE;
    else
      case (st_r)
        memctl_pkg::ST_IDLE:
          if (extReq && extDefined && aligned)
            st_r <= memctl_pkg::ST_WAIT;
        memctl_pkg::ST_WAIT:
          if (cnt_r == '0)
            st_r <= bankFloat[selIdx*`FLOAT_W +: `FLOAT_W] != '0
                    ? memctl_pkg::ST_FLOAT : memctl_pkg::ST_IDLE;
        default:
          if (cnt_r == '0)
            st_r <= memctl_pkg::ST_IDLE;
      endcase
  // Early read saves one wait cycle on a read.
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
      cnt_r <= '0;
    else if (st_r == memctl_pkg::ST_IDLE)
      cnt_r <= (bankEarlyRead[selIdx] && !wr && bankWait[selIdx*`WAIT_W +: `WAIT_W] != '0)
               ? bankWait[selIdx*`WAIT_W +: `WAIT_W] - 1'b1
               : bankWait[selIdx*`WAIT_W +: `WAIT_W];
    else if (st_r == memctl_pkg::ST_WAIT && cnt_r == '0)
      cnt_r <= bankFloat[selIdx*`FLOAT_W +: `FLOAT_W];
    else if (cnt_r != '0)
      cnt_r <= cnt_r - 1'b1;
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
    begin
      chipSel_n    <= '1;
      extAddr      <= '0;
      extData      <= '0;
      extRead_n    <= 1'b1;
      extWrite_n   <= 1'b1;
      extByteSel_n <= 2'h3;
    end
    else if (st_r == memctl_pkg::ST_IDLE && extReq && extDefined && aligned)
    begin
      chipSel_n <= ~(BANKS'(1) << selIdx);
      extAddr   <= addr[23:0];
      extRead_n  <= wr;
      extWrite_n <= !wr;
      if (bootWin ? bootByteWide : !bankWide[selIdx])
      begin
        extData      <= {8'h00, wdata[8*addr[1:0] +: 8]};
        extByteSel_n <= 2'h2;
      end
      else
      begin
        extData <= addr[1] ? wdata[31:16] : wdata[15:0];
        // Byte write mode gates only write strobes; reads enable both bytes.
        extByteSel_n <= (bankByteWrite[selIdx] && !wr) ? 2'h0
                        : ~(addr[1] ? be[3:2] : be[1:0]);
      end
    end
    else if (st_r == memctl_pkg::ST_WAIT && cnt_r == '0)
    begin
      chipSel_n    <= '1;
      extRead_n    <= 1'b1;
      extWrite_n   <= 1'b1;
      extByteSel_n <= 2'h3;
    end
  // Word accesses to narrow banks are one beat each; the core splits them.
  assign ready   = (req && reg_w != memctl_pkg::REG_EXT && !bootWin) ||
                   (st_r == memctl_pkg::ST_WAIT && cnt_r == '0) || abort;
  assign extBusy = st_r != memctl_pkg::ST_IDLE;
endmodule // memory_map_boot_remap_decoder
`default_nettype wire

// *** hw/strap_latch.sv ***
// Catches the boot width strap after it has been stable before reset release.
// Assumes the strap pin is asynchronous and passes a three-stage synchroniser.
`timescale 1ns/100ps
`default_nettype none
`include "memctl_consts.svh"
module strap_latch (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic pinReset,
  input  wire logic strapPin,
  output logic      bootByteWide
);
  logic [2:0]               sync_r;
  logic [`STRAP_CNT_W-1:0]  stable_r;
  logic                     pinResetDly_r;
  // No reset on the synchroniser: clearing it would fake a strap change at reset release
  // and eat into the ten-cycle window that the board guarantees.
  always_ff @(posedge sys_clk)
    sync_r <= {sync_r[1:0], strapPin};
  // Stability is counted only while the pin reset is held.
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
      stable_r <= '0;
    else if (!pinReset || sync_r[2] != sync_r[1])
      stable_r <= '0;
    else if (stable_r != `STRAP_HOLD_CYC)
      stable_r <= stable_r + 1'b1;
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
      pinResetDly_r <= 1'b0;
    else
      pinResetDly_r <= pinReset;
  // Not reset by sys_rst, so a watchdog reset keeps the boot mode.
  always_ff @(posedge sys_clk)
    if (pinResetDly_r && !pinReset && stable_r == `STRAP_HOLD_CYC)
      bootByteWide <= sync_r[2];
endmodule // strap_latch
`default_nettype wire

// *** verification/core_model.sv ***
// Processor core model issuing one access at a time.
// Assumes ready and abort are settled by the falling clock edge.
`timescale 1ns/100ps
`default_nettype none
module core_model (
  input  wire logic        sys_clk,
  input  wire logic        ready,
  input  wire logic        abort,
  input  wire logic        extBusy,
  input  wire logic [1:0]  region,
  input  wire logic [3:0]  sramBe,
  output logic             req,
  output logic             wr,
  output logic [1:0]       size,
  output logic [31:0]      addr,
  output logic [31:0]      wdata
);
  initial
  begin
    req = 1'b0;
    wr = 1'b0;
    size = 2'h0;
    addr = 32'h0;
    wdata = 32'h0;
  end
  // Holds the request until ready, then scrambles the lines so stale values never match.
  task automatic access(input logic w, input logic [1:0] s, input logic [31:0] a,
                        output int lat, output logic ab, output logic [1:0] rg,
                        output logic [3:0] be);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (extBusy !== 1'b0 && n < 64)
    begin
      @(negedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    req <= 1'b1;
    wr <= w;
    size <= s;
    addr <= a;
    wdata <= ~a;
    lat = 0;
    @(negedge sys_clk);
    while (ready !== 1'b1 && lat < 64)
    begin
      @(negedge sys_clk);
      lat++;
    end
    ab = abort;
    rg = region;
    be = sramBe;
    @(posedge sys_clk);
    req <= 1'b0;
    addr <= ~a;
    wdata <= a;
  endtask
endmodule // core_model
`default_nettype wire

// *** verification/memmap_assertions.sv ***
// Port checker for the memory map decoder.
// Assumes it is bound onto the top module and sees one clock domain.
`timescale 1ns/100ps
`default_nettype none
module memmap_assertions #(
  parameter int BANKS = 8
) (
  input wire logic             sys_clk,
  input wire logic             sys_rst,
  input wire logic             pinReset,
  input wire logic             boot_width_strap,
  input wire logic             remap_command_bit,
  input wire logic [BANKS-1:0] bankBig,
  input wire logic             req,
  input wire logic [31:0]      addr,
  input wire logic             ready,
  input wire logic             abort,
  input wire logic             remapDone,
  input wire logic             bootByteWide,
  input wire logic [1:0]       region,
  input wire logic             gpioIn,
  input wire logic             strapOe_n,
  input wire logic [BANKS-1:0] chipSel_n,
  input wire logic             extBusy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Counts cycles since the reset pin let go, so a late strap sync is tolerated.
  logic [3:0] relCnt_r;
  always_ff @(posedge sys_clk)
    if (pinReset)
      relCnt_r <= 4'h0;
    else if (relCnt_r != 4'hf)
      relCnt_r <= relCnt_r + 4'h1;
  sequence extStart;
    req && region == memctl_pkg::REG_EXT && !ready;
  endsequence
  sequence extWait;
    extStart ##1 (req && !ready);
  endsequence
  a_per_no_abort: assert property (req && addr >= 32'hffc0_0000 |->
    ready && !abort && region == memctl_pkg::REG_PER) else $error("peripheral access misdecoded");
  a_sram_one_cycle: assert property (req && remapDone && addr < 32'h0040_0000 |->
    ready && !abort && region == memctl_pkg::REG_INT) else $error("sram access not single cycle");
  a_undef_ext_abort: assert property (req && remapDone && bankBig == '0 &&
    addr >= 32'h00c0_0000 && addr < 32'hffc0_0000 |-> abort && ready) else $error("no abort");
  a_abort_with_ready: assert property (abort |-> ready) else $error("abort without ready");
  a_idle_no_select: assert property (!extBusy |-> chipSel_n == '1) else $error("select idle");
  a_ext_bounded: assert property (extStart |-> ##[1:10] ready) else $error("external hang");
  a_cs_in_wait: assert property (extWait |-> chipSel_n != '1) else $error("no chip select");
  a_remap_sets: assert property (remap_command_bit |=> remapDone) else $error("remap lost");
  a_remap_sticky: assert property (remapDone && !pinReset |=> remapDone) else $error("undone");
  a_strap_kept: assert property (relCnt_r == 4'hf |-> $stable(bootByteWide))
    else $error("boot width changed outside pin reset");
  a_strap_released: assert property (pinReset |-> strapOe_n) else $error("pin driven");
  a_pin_raw: assert property (gpioIn == boot_width_strap) else $error("pin input wrong");
endmodule // memmap_assertions
bind memory_map_boot_remap_decoder memmap_assertions #(.BANKS(BANKS)) u_memmap_assertions (
  .sys_clk, .sys_rst, .pinReset, .boot_width_strap, .remap_command_bit, .bankBig, .req, .addr,
  .ready, .abort, .remapDone, .bootByteWide, .region, .gpioIn, .strapOe_n, .chipSel_n, .extBusy
);
`default_nettype wire

// *** verification/memory_map_boot_remap_decoder_test.sv ***
// Self-checking bench for the memory map decoder.
// Assumes the bound checker and the core model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module memory_map_boot_remap_decoder_test;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        pinReset = 1'b1;
  logic        strap = 1'b1;
  logic        gpioOut = 1'b0;
  logic        gpioOe_n = 1'b1;
  logic        remapCmd = 1'b0;
  logic [7:0]  bankEn = 8'hff;
  logic [7:0]  earlyRd = 8'h00;
  logic [7:0]  byteWr = 8'h00;
  logic [7:0]  chipSel, lastCs;
  logic [23:0] extAddr, lastExt;
  logic [1:0]  extBs, lastBs;
  logic [31:0] perAddr, lastPer;
  logic        perSel;
  logic        req, wr, ready, abort, remapDone, bootWide, extBusy, gpioIn, strapOut, strapOe_n;
  logic [1:0]  size, region, rg;
  logic [3:0]  sramBe, be;
  logic [31:0] addr, wdata;
  logic        ab;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          lat, lat2;
  always #5 sys_clk = ~sys_clk;
  memory_map_boot_remap_decoder u_memory_map_boot_remap_decoder (.sys_clk, .sys_rst, .pinReset,
    .boot_width_strap(strap), .gpioOut, .gpioOe_n, .gpioIn, .strapOut, .strapOe_n,
    .remap_command_bit(remapCmd), .bankEn, .bankBig(8'h00), .bankWide(8'hff),
    .bankByteWrite(byteWr), .bankEarlyRead(earlyRd), .bankWait(24'h0000cd),
    .bankFloat(24'h492492), .req, .wr, .size, .addr, .wdata, .ready, .abort, .remapDone,
    .bootByteWide(bootWide), .region, .sramSel(), .sramWe(), .sramBe, .sramAddr(), .sramWdata(),
    .perSel, .perAddr, .chipSel_n(chipSel), .extAddr, .extData(), .extRead_n(), .extWrite_n(),
    .extByteSel_n(extBs), .extBusy);
  // Strobes stand only while an access is in flight, so the last active values are kept.
  always @(negedge sys_clk)
  begin
    if (chipSel != 8'hff)
    begin
      lastCs = chipSel;
      lastExt = extAddr;
      lastBs = extBs;
    end
    if (perSel)
      lastPer = perAddr;
  end
  core_model core (.sys_clk, .ready, .abort, .extBusy, .region, .sramBe, .req, .wr, .size,
    .addr, .wdata);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // The strap is held steady well past the ten cycles before the pin lets go.
  task automatic pin_reset(input logic s);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    pinReset <= 1'b1;
    strap <= s;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (12) @(posedge sys_clk);
    pinReset <= 1'b0;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    $display("reset done");
  endtask
  logic [31:0] sAd [3] = '{32'h0, 32'h1, 32'h2};
  logic [1:0]  sSz [3] = '{2'h2, 2'h0, 2'h1};
  logic [3:0]  sBe [3] = '{4'hf, 4'h2, 4'hc};
  logic [31:0] bad [3] = '{32'h2000_0000, 32'h0050_0002, 32'h0070_0000};
  initial
  begin
    pin_reset(1'b1);
    chk(bootWide, 1, "boot width");
    core.access(1'b1, 2'h0, 32'hffff_f001, lat, ab, rg, be);
    chk(32'(lat), 0, "per latency");
    chk(ab, 0, "per abort");
    chk(rg, 3, "per region");
    chk(lastPer, 32'hffff_f000, "per word address");
    core.access(1'b0, 2'h0, 32'h0000_0000, lat, ab, rg, be);
    chk(32'(lat), 6, "boot latency");
    chk({ab, lastCs}, 9'h0fe, "boot on chip select zero");
    chk(lastBs, 2'h2, "boot byte lane");
    core.access(1'b0, 2'h0, 32'h0050_0000, lat, ab, rg, be);
    chk(ab, 1, "bank one before remap");
    @(posedge sys_clk) remapCmd <= 1'b1;
    @(posedge sys_clk) remapCmd <= 1'b0;
    @(negedge sys_clk) chk(remapDone, 1, "remap");
    for (int i = 0; i < 3; i++)
    begin
      core.access(1'b1, sSz[i], sAd[i], lat, ab, rg, be);
      chk(32'(lat), 0, "sram latency");
      chk(rg, 0, "sram at zero");
      chk(be, sBe[i], "byte lanes");
    end
    $display("sram test done");
    core.access(1'b0, 2'h0, 32'h0050_0000, lat2, ab, rg, be);
    chk(rg, 1, "ext region");
    core.access(1'b0, 2'h0, 32'h0060_0000, lat, ab, rg, be);
    chk(32'(lat - lat2), 2, "wait states");
    chk({lastCs, lastExt}, 32'hfb60_0000, "bank two select");
    chk(lastBs, 2'h2, "byte select lane");
    @(posedge sys_clk) earlyRd <= 8'h04;
    byteWr <= 8'h04;
    core.access(1'b0, 2'h0, 32'h0060_0000, lat2, ab, rg, be);
    chk(32'(lat - lat2), 1, "early read");
    chk(lastBs, 2'h0, "byte write read lanes");
    @(posedge sys_clk) bankEn <= 8'hf7;
    for (int i = 0; i < 3; i++)
    begin
      core.access(1'b0, 2'h2, bad[i], lat, ab, rg, be);
      chk(ab, 1, "refused access");
    end
    $display("external test done");
    @(posedge sys_clk) gpioOe_n <= 1'b0;
    strap <= 1'b0;
    @(negedge sys_clk) chk({strapOe_n, strapOut, gpioIn}, 0, "pin as io");
    @(posedge sys_clk) gpioOe_n <= 1'b1;
    sys_rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(negedge sys_clk) chk(remapDone, 0, "remap after reset");
    chk(bootWide, 1, "boot width kept");
    pin_reset(1'b0);
    chk(bootWide, 0, "boot width 16");
    stop_test;
  end
  // The tests need about 110 cycles; over twenty-five times that marks a hang.
  initial
  begin
    repeat (3000) @(posedge sys_clk);
    mismatches++;
    stop_test;
  end
endmodule // memory_map_boot_remap_decoder_test
`default_nettype wire
